// *** src/dac_modulator_tweak_regs.sv ***
// modulator coefficient, gain, pump hysteresis and oscillator trim registers
// assumes an apb master on i_ref_clk at 125 mhz and an async active-low reset
//
// Notes on behaviour
// - register 0x12 bits 7..4 zero left primary a0,b1,b2,b3 when set; reset 0
// - register 0x12 bits 3..0 zero right primary a0,b1,b2,b3 when set; reset 0
// - register 0x14 bits 7..4 zero left secondary a0,b1,b2,b3 when set; reset 0
// - register 0x14 bits 3..0 zero right secondary a0,b1,b2,b3 when set; reset 0
// - register 0x13 bit 7 selects left primary loop gain; reset 0
// - register 0x13 bit 5 sets left primary upper bit count; reset 0
// - register 0x13 bit 3 selects right primary loop gain; reset 0
// - register 0x13 bit 1 sets right primary upper bit count; even bits reserved
// - register 0x15 bit 7 selects left secondary loop gain; reset 0
// - register 0x15 bit 5 sets left secondary upper bit count; reset 0
// - register 0x15 bit 3 selects right secondary loop gain; reset 0
// - register 0x15 bit 1 sets right secondary upper bit count; even bits reserved
// - registers 0x16 and 0x17 bits 1..0 set pump detector hysteresis; reset 1
// - register 0x18 bit 1 trims oscillator bias, reset 0; bit 2 resets 1
`timescale 1ns/1ps
`default_nettype none
`include "dac_tweak_map.svh"

module dac_modulator_tweak_regs #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // primary modulator coefficient forcing
    output logic o_left_pri_coef_a_zero,
    output logic o_left_pri_coef_b_first_zero,
    output logic o_left_pri_coef_b_second_zero,
    output logic o_left_pri_coef_b_third_zero,
    output logic o_right_pri_coef_a_zero,
    output logic o_right_pri_coef_b_first_zero,
    output logic o_right_pri_coef_b_second_zero,
    output logic o_right_pri_coef_b_third_zero,
    // secondary modulator coefficient forcing
    output logic o_left_sec_coef_a_zero,
    output logic o_left_sec_coef_b_first_zero,
    output logic o_left_sec_coef_b_second_zero,
    output logic o_left_sec_coef_b_third_zero,
    output logic o_right_sec_coef_a_zero,
    output logic o_right_sec_coef_b_first_zero,
    output logic o_right_sec_coef_b_second_zero,
    output logic o_right_sec_coef_b_third_zero,
    // loop gain and upper bit count
    output logic o_left_pri_loop_gain,
    output logic o_left_pri_upper_bit_count,
    output logic o_right_pri_loop_gain,
    output logic o_right_pri_upper_bit_count,
    output logic o_left_sec_loop_gain,
    output logic o_left_sec_upper_bit_count,
    output logic o_right_sec_loop_gain,
    output logic o_right_sec_upper_bit_count,
    // charge pump and oscillator trims
    output logic [1:0] o_pump_detector_hysteresis_a,
    output logic [1:0] o_pump_detector_hysteresis_b,
    output logic o_oscillator_bias_current_trim,
    output logic o_oscillator_bias_aux_hi,
    output logic o_oscillator_bias_aux_lo
);

    localparam int NUM_REGS = 7;

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    generate
        if (ADDR_W < 7) begin : g_narrow_addr_w
            $error("address width must be at least 7 bits to reach the last register");
        end
        if (ADDR_W > 32) begin : g_wide_addr_w
            $error("address width must not exceed 32 bits");
        end
        if (NUM_REGS != `LAST_IDX - `FIRST_IDX + 1) begin : g_bad_span
            $error("slot count does not match the register span");
        end
    endgenerate

    // ----------------------------------------------------------------
    // reset value of each slot
    // ----------------------------------------------------------------
    function automatic logic [7:0] slot_reset(input int slot);
        logic [7:0] val;
        val = `COEF_ZERO_RST;
        case (slot)
            0: val = `COEF_ZERO_RST;
            1: val = `GAIN_UB_RST;
            2: val = `COEF_ZERO_RST;
            3: val = `GAIN_UB_RST;
            4: val = `PUMP_HYST_RST;
            5: val = `PUMP_HYST_RST;
            6: val = `OSC_BIAS_RST;
            default: val = `COEF_ZERO_RST;
        endcase
        return val;
    endfunction : slot_reset

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    logic addr_hit;
    dac_tweak_pkg::tweak_slot_t addr_slot;

    tweak_addr_decode #(
        .ADDR_W(ADDR_W)
    ) u_decode (
        .i_addr(i_paddr),
        .o_hit(addr_hit),
        .o_slot(addr_slot)
    );

    // ----------------------------------------------------------------
    // apb phases
    // ----------------------------------------------------------------
    logic setup_phase;
    logic access_phase;
    logic wr_go;
    logic rd_go;
    logic [7:0] wr_byte;

    assign setup_phase = i_psel & ~i_penable;
    assign access_phase = i_psel & i_penable;
    // only byte lane 0 holds data; a write with lane 0 off changes nothing
    assign wr_go = access_phase & i_pwrite & addr_hit & i_pstrb[0];
    assign rd_go = ~i_pwrite & addr_hit;
    assign wr_byte = i_pwdata[7:0];

    // ----------------------------------------------------------------
    // write strobes, one per slot
    // ----------------------------------------------------------------
    logic [NUM_REGS-1:0] wr_en;

    always_comb begin
        wr_en = '0;
        if (wr_go) begin
            case (addr_slot)
                dac_tweak_pkg::SLOT_PRI_COEF: wr_en[0] = 1'b1;
                dac_tweak_pkg::SLOT_PRI_GAIN: wr_en[1] = 1'b1;
                dac_tweak_pkg::SLOT_SEC_COEF: wr_en[2] = 1'b1;
                dac_tweak_pkg::SLOT_SEC_GAIN: wr_en[3] = 1'b1;
                dac_tweak_pkg::SLOT_HYST_A: wr_en[4] = 1'b1;
                dac_tweak_pkg::SLOT_HYST_B: wr_en[5] = 1'b1;
                dac_tweak_pkg::SLOT_OSC_TRIM: wr_en[6] = 1'b1;
                default: wr_en = '0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // register storage
    // ----------------------------------------------------------------
    dac_tweak_pkg::reg_byte_t reg_q [NUM_REGS];

    genvar g;
    generate
        for (g = 0; g < NUM_REGS; g++) begin : g_regs
            tweak_byte_reg #(
                .RESET_VAL(slot_reset(g))
            ) u_reg (
                .i_ref_clk(i_ref_clk),
                .i_rst_b(i_rst_b),
                .i_we(wr_en[g]),
                .i_wdata(wr_byte),
                .o_q(reg_q[g])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // read select
    // ----------------------------------------------------------------
    logic [7:0] rd_mux;

    always_comb begin
        case (addr_slot)
            dac_tweak_pkg::SLOT_PRI_COEF: rd_mux = reg_q[0];
            dac_tweak_pkg::SLOT_PRI_GAIN: rd_mux = reg_q[1];
            dac_tweak_pkg::SLOT_SEC_COEF: rd_mux = reg_q[2];
            dac_tweak_pkg::SLOT_SEC_GAIN: rd_mux = reg_q[3];
            dac_tweak_pkg::SLOT_HYST_A: rd_mux = reg_q[4];
            dac_tweak_pkg::SLOT_HYST_B: rd_mux = reg_q[5];
            dac_tweak_pkg::SLOT_OSC_TRIM: rd_mux = reg_q[6];
            default: rd_mux = 8'h00;
        endcase
    end

    // ----------------------------------------------------------------
    // read data, captured in the setup cycle
    // ----------------------------------------------------------------
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;

    always_comb begin
        rdata_next = rdata_reg;
        if (setup_phase) begin
            rdata_next = rd_go ? {24'h000000, rd_mux} : 32'h00000000;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rdata_reg <= 32'h00000000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // ----------------------------------------------------------------
    // slave error flag, captured in the setup cycle
    // ----------------------------------------------------------------
    logic err_reg;
    logic err_next;

    always_comb begin
        err_next = err_reg;
        if (setup_phase) begin
            err_next = ~addr_hit;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            err_reg <= 1'b0;
        end else begin
            err_reg <= err_next;
        end
    end

    // ----------------------------------------------------------------
    // bus answer
    // ----------------------------------------------------------------
    // zero wait states: the answer stands in the first access cycle
    assign o_pready = access_phase;
    assign o_pslverr = access_phase & err_reg;
    assign o_prdata = rdata_reg;

    // ----------------------------------------------------------------
    // primary coefficient forcing
    // ----------------------------------------------------------------
    assign o_left_pri_coef_a_zero = reg_q[0][`LEFT_A_ZERO_BIT];
    assign o_left_pri_coef_b_first_zero = reg_q[0][`LEFT_B_FIRST_ZERO_BIT];
    assign o_left_pri_coef_b_second_zero = reg_q[0][`LEFT_B_SECOND_ZERO_BIT];
    assign o_left_pri_coef_b_third_zero = reg_q[0][`LEFT_B_THIRD_ZERO_BIT];
    assign o_right_pri_coef_a_zero = reg_q[0][`RIGHT_A_ZERO_BIT];
    assign o_right_pri_coef_b_first_zero = reg_q[0][`RIGHT_B_FIRST_ZERO_BIT];
    assign o_right_pri_coef_b_second_zero = reg_q[0][`RIGHT_B_SECOND_ZERO_BIT];
    assign o_right_pri_coef_b_third_zero = reg_q[0][`RIGHT_B_THIRD_ZERO_BIT];

    // ----------------------------------------------------------------
    // secondary coefficient forcing
    // ----------------------------------------------------------------
    assign o_left_sec_coef_a_zero = reg_q[2][`LEFT_A_ZERO_BIT];
    assign o_left_sec_coef_b_first_zero = reg_q[2][`LEFT_B_FIRST_ZERO_BIT];
    assign o_left_sec_coef_b_second_zero = reg_q[2][`LEFT_B_SECOND_ZERO_BIT];
    assign o_left_sec_coef_b_third_zero = reg_q[2][`LEFT_B_THIRD_ZERO_BIT];
    assign o_right_sec_coef_a_zero = reg_q[2][`RIGHT_A_ZERO_BIT];
    assign o_right_sec_coef_b_first_zero = reg_q[2][`RIGHT_B_FIRST_ZERO_BIT];
    assign o_right_sec_coef_b_second_zero = reg_q[2][`RIGHT_B_SECOND_ZERO_BIT];
    assign o_right_sec_coef_b_third_zero = reg_q[2][`RIGHT_B_THIRD_ZERO_BIT];

    // ----------------------------------------------------------------
    // primary loop gain and upper bit count
    // ----------------------------------------------------------------
    assign o_left_pri_loop_gain = reg_q[1][`LEFT_LOOP_GAIN_BIT];
    assign o_left_pri_upper_bit_count = reg_q[1][`LEFT_UPPER_BITS_BIT];
    assign o_right_pri_loop_gain = reg_q[1][`RIGHT_LOOP_GAIN_BIT];
    assign o_right_pri_upper_bit_count = reg_q[1][`RIGHT_UPPER_BITS_BIT];

    // ----------------------------------------------------------------
    // secondary loop gain and upper bit count
    // ----------------------------------------------------------------
    assign o_left_sec_loop_gain = reg_q[3][`LEFT_LOOP_GAIN_BIT];
    assign o_left_sec_upper_bit_count = reg_q[3][`LEFT_UPPER_BITS_BIT];
    assign o_right_sec_loop_gain = reg_q[3][`RIGHT_LOOP_GAIN_BIT];
    assign o_right_sec_upper_bit_count = reg_q[3][`RIGHT_UPPER_BITS_BIT];

    // ----------------------------------------------------------------
    // charge pump detector hysteresis
    // ----------------------------------------------------------------
    assign o_pump_detector_hysteresis_a = reg_q[4][`HYST_MSB:`HYST_LSB];
    assign o_pump_detector_hysteresis_b = reg_q[5][`HYST_MSB:`HYST_LSB];

    // ----------------------------------------------------------------
    // oscillator bias trim
    // ----------------------------------------------------------------
    assign o_oscillator_bias_current_trim = reg_q[6][`OSC_TRIM_BIT];
    assign o_oscillator_bias_aux_hi = reg_q[6][`OSC_AUX_HI_BIT];
    assign o_oscillator_bias_aux_lo = reg_q[6][`OSC_AUX_LO_BIT];

endmodule : dac_modulator_tweak_regs

`default_nettype wire

// *** common/dac_tweak_map.svh ***
// register indices, field positions and reset values of the modulator tweak bank
// assumes byte address = 4 * index on a 32-bit apb bus
`ifndef DAC_TWEAK_MAP_SVH
`define DAC_TWEAK_MAP_SVH

// ----------------------------------------------------------------
// register indices
// ----------------------------------------------------------------
`define PRI_COEF_ZERO_IDX 5'h12
`define PRI_GAIN_UB_IDX 5'h13
`define SEC_COEF_ZERO_IDX 5'h14
`define SEC_GAIN_UB_IDX 5'h15
`define PUMP_HYST_A_IDX 5'h16
`define PUMP_HYST_B_IDX 5'h17
`define OSC_BIAS_TRIM_IDX 5'h18
`define FIRST_IDX 5'h12
`define LAST_IDX 5'h18

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define LEFT_A_ZERO_BIT 7
`define LEFT_B_FIRST_ZERO_BIT 6
`define LEFT_B_SECOND_ZERO_BIT 5
`define LEFT_B_THIRD_ZERO_BIT 4
`define RIGHT_A_ZERO_BIT 3
`define RIGHT_B_FIRST_ZERO_BIT 2
`define RIGHT_B_SECOND_ZERO_BIT 1
`define RIGHT_B_THIRD_ZERO_BIT 0
`define LEFT_LOOP_GAIN_BIT 7
`define LEFT_UPPER_BITS_BIT 5
`define RIGHT_LOOP_GAIN_BIT 3
`define RIGHT_UPPER_BITS_BIT 1
`define HYST_MSB 1
`define HYST_LSB 0
`define OSC_AUX_HI_BIT 2
`define OSC_TRIM_BIT 1
`define OSC_AUX_LO_BIT 0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define COEF_ZERO_RST 8'h00
`define GAIN_UB_RST 8'h00
`define PUMP_HYST_RST 8'h01
`define OSC_BIAS_RST 8'h04

`endif

// *** common/dac_tweak_pkg.sv ***
// types shared by the modulator tweak register bank
// assumes the map header supplies all numeric constants except the slot codes defined below
package dac_tweak_pkg;

    typedef logic [7:0] reg_byte_t;

    // ----------------------------------------------------------------
    // slot of each register within the bank
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        SLOT_PRI_COEF = 3'h0,
        SLOT_PRI_GAIN = 3'h1,
        SLOT_SEC_COEF = 3'h2,
        SLOT_SEC_GAIN = 3'h3,
        SLOT_HYST_A = 3'h4,
        SLOT_HYST_B = 3'h5,
        SLOT_OSC_TRIM = 3'h6,
        SLOT_NONE = 3'h7
    } tweak_slot_t;

endpackage : dac_tweak_pkg

// *** src/tweak_byte_reg.sv ***
// one byte-wide read/write register with a constant reset value
// assumes a single clock and an asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none

module tweak_byte_reg #(
    parameter logic [7:0] RESET_VAL = 8'h00
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    // write side
    input wire logic i_we,
    input wire logic [7:0] i_wdata,
    // stored value
    output logic [7:0] o_q
);

    logic [7:0] q_reg;
    logic [7:0] q_next;

    always_comb begin
        q_next = i_we ? i_wdata : q_reg;
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            q_reg <= RESET_VAL;
        end else begin
            q_reg <= q_next;
        end
    end

    assign o_q = q_reg;

endmodule : tweak_byte_reg

`default_nettype wire

// *** src/tweak_addr_decode.sv ***
// maps an apb byte address onto a slot of the tweak bank
// assumes word-aligned access, byte address = 4 * register index
`timescale 1ns/1ps
`default_nettype none
`include "dac_tweak_map.svh"

module tweak_addr_decode #(
    parameter int ADDR_W = 8
) (
    // address in
    input wire logic [ADDR_W-1:0] i_addr,
    // decode out
    output logic o_hit,
    output dac_tweak_pkg::tweak_slot_t o_slot
);

    logic [ADDR_W-3:0] idx;
    logic [ADDR_W-3:0] offs;

    always_comb begin
        idx = i_addr[ADDR_W-1:2];
        offs = idx - (ADDR_W-2)'(`FIRST_IDX);
        o_hit = (i_addr[1:0] == 2'h0) &&
                (idx >= (ADDR_W-2)'(`FIRST_IDX)) &&
                (idx <= (ADDR_W-2)'(`LAST_IDX));
        o_slot = o_hit ? dac_tweak_pkg::tweak_slot_t'(offs[2:0])
                       : dac_tweak_pkg::SLOT_NONE;
    end

endmodule : tweak_addr_decode

`default_nettype wire

// *** dv/dac_modulator_tweak_regs_sva.sv ***
// assertions on the apb side and several field outputs of the tweak bank
// assumes one clock and an async active-low reset; bound to the top module below
`timescale 1ns/1ps
`default_nettype none
`include "dac_tweak_map.svh"

module dac_modulator_tweak_regs_sva #(
    parameter int ADDR_W = 8
) (
    // clock, reset and apb
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    // watched fields
    input wire logic o_left_pri_coef_a_zero,
    input wire logic o_right_pri_coef_b_third_zero,
    input wire logic o_left_sec_coef_a_zero,
    input wire logic o_left_pri_loop_gain,
    input wire logic [1:0] o_pump_detector_hysteresis_a,
    input wire logic [1:0] o_pump_detector_hysteresis_b,
    input wire logic o_oscillator_bias_current_trim
);
    // ----------------------------------------------------------------
    // helpers, assertions and covers
    // ----------------------------------------------------------------
    logic acc;
    logic wr;
    logic bad;
    assign acc = i_psel && i_penable;
    assign wr = acc && i_pwrite && i_pstrb[0];
    assign bad = i_paddr[1:0] != 2'b00 || i_paddr < ADDR_W'(4 * `FIRST_IDX)
        || i_paddr > ADDR_W'(4 * `LAST_IDX);

    function automatic logic at(input logic [ADDR_W-1:0] a, input logic [4:0] idx);
        return a == ADDR_W'(4 * idx);
    endfunction : at

    default clocking dc @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_b);

    AST_ZERO_WAIT: assert property (o_pready == acc)
        else $error("pready not tied to access phase");
    AST_REFUSE: assert property (acc |-> o_pslverr == bad
        && (i_pwrite || !bad || o_prdata == 32'h0)) else $error("bad address handling");
    AST_LPRI_A: assert property (wr && at(i_paddr, `PRI_COEF_ZERO_IDX)
        |=> o_left_pri_coef_a_zero == $past(i_pwdata[7])) else $error("left pri a0 wrong");
    AST_RPRI_B3: assert property (wr && at(i_paddr, `PRI_COEF_ZERO_IDX)
        |=> o_right_pri_coef_b_third_zero == $past(i_pwdata[0])) else $error("right pri b3");
    AST_LSEC_A: assert property (wr && at(i_paddr, `SEC_COEF_ZERO_IDX)
        |=> o_left_sec_coef_a_zero == $past(i_pwdata[7])) else $error("left sec a0 wrong");
    AST_LPRI_GAIN: assert property (wr && at(i_paddr, `PRI_GAIN_UB_IDX)
        |=> o_left_pri_loop_gain == $past(i_pwdata[7])) else $error("left pri gain wrong");
    AST_HYST_A: assert property (wr && at(i_paddr, `PUMP_HYST_A_IDX)
        |=> o_pump_detector_hysteresis_a == $past(i_pwdata[1:0])) else $error("hyst a wrong");
    AST_OSC_TRIM: assert property (wr && at(i_paddr, `OSC_BIAS_TRIM_IDX)
        |=> o_oscillator_bias_current_trim == $past(i_pwdata[1])) else $error("trim wrong");
    AST_HYST_B_HOLD: assert property (!(wr && at(i_paddr, `PUMP_HYST_B_IDX))
        |=> $stable(o_pump_detector_hysteresis_b)) else $error("hyst b changed unwritten");

    cover property (wr && at(i_paddr, `OSC_BIAS_TRIM_IDX));
    cover property (acc && bad);
    cover property (acc && !i_pwrite && !bad);
endmodule : dac_modulator_tweak_regs_sva

bind dac_modulator_tweak_regs dac_modulator_tweak_regs_sva #(.ADDR_W(ADDR_W)) u_sva (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_left_pri_coef_a_zero(o_left_pri_coef_a_zero),
    .o_right_pri_coef_b_third_zero(o_right_pri_coef_b_third_zero),
    .o_left_sec_coef_a_zero(o_left_sec_coef_a_zero),
    .o_left_pri_loop_gain(o_left_pri_loop_gain),
    .o_pump_detector_hysteresis_a(o_pump_detector_hysteresis_a),
    .o_pump_detector_hysteresis_b(o_pump_detector_hysteresis_b),
    .o_oscillator_bias_current_trim(o_oscillator_bias_current_trim));
`default_nettype wire

// *** dv/dac_modulator_tweak_regs_tb.sv ***
// self-checking bench for the modulator tweak register bank
// assumes zero-wait apb answers; the checker binds itself from its own file
`timescale 1ns/1ps
`default_nettype none
`include "dac_tweak_map.svh"

module dac_modulator_tweak_regs_tb;
    // ----------------------------------------------------------------
    // stimulus, design, model and tests
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    logic i_ref_clk = 1'b0, i_rst_b = 1'b0;
    logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
    logic [ADDR_W-1:0] i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h0;
    logic [3:0] i_pstrb = 4'h0;
    logic [31:0] o_prdata;
    logic o_pready, o_pslverr;
    wire logic [7:0] pz, sz;
    wire logic [3:0] pg, sg;
    wire logic [1:0] ha, hb;
    wire logic [2:0] ot;
    int errors = 0;
    int n_tests = 0;
    int seed;
    logic [ADDR_W-1:0] a;
    logic [7:0] mdl [7];
    logic [7:0] rst_tab [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h04};
    logic [ADDR_W-1:0] bad_tab [4] = '{8'h44, 8'h64, 8'h49, 8'hfe};

    dac_modulator_tweak_regs #(.ADDR_W(ADDR_W)) DUT (
        .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
        .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
        .o_left_pri_coef_a_zero(pz[7]), .o_left_pri_coef_b_first_zero(pz[6]),
        .o_left_pri_coef_b_second_zero(pz[5]), .o_left_pri_coef_b_third_zero(pz[4]),
        .o_right_pri_coef_a_zero(pz[3]), .o_right_pri_coef_b_first_zero(pz[2]),
        .o_right_pri_coef_b_second_zero(pz[1]), .o_right_pri_coef_b_third_zero(pz[0]),
        .o_left_sec_coef_a_zero(sz[7]), .o_left_sec_coef_b_first_zero(sz[6]),
        .o_left_sec_coef_b_second_zero(sz[5]), .o_left_sec_coef_b_third_zero(sz[4]),
        .o_right_sec_coef_a_zero(sz[3]), .o_right_sec_coef_b_first_zero(sz[2]),
        .o_right_sec_coef_b_second_zero(sz[1]), .o_right_sec_coef_b_third_zero(sz[0]),
        .o_left_pri_loop_gain(pg[3]), .o_left_pri_upper_bit_count(pg[2]),
        .o_right_pri_loop_gain(pg[1]), .o_right_pri_upper_bit_count(pg[0]),
        .o_left_sec_loop_gain(sg[3]), .o_left_sec_upper_bit_count(sg[2]),
        .o_right_sec_loop_gain(sg[1]), .o_right_sec_upper_bit_count(sg[0]),
        .o_pump_detector_hysteresis_a(ha), .o_pump_detector_hysteresis_b(hb),
        .o_oscillator_bias_aux_hi(ot[2]), .o_oscillator_bias_current_trim(ot[1]),
        .o_oscillator_bias_aux_lo(ot[0]));

    initial begin
        forever #4ns i_ref_clk = ~i_ref_clk;
    end

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // gain and upper bit count fields sit at bits 7, 5, 3 and 1
    function automatic logic [3:0] odd_bits(input logic [7:0] b);
        return {b[7], b[5], b[3], b[1]};
    endfunction : odd_bits

    task automatic check_fields;
        check("pri coef zero", 32'(pz), 32'(mdl[0]));
        check("pri gain", 32'(pg), 32'(odd_bits(mdl[1])));
        check("sec coef zero", 32'(sz), 32'(mdl[2]));
        check("sec gain", 32'(sg), 32'(odd_bits(mdl[3])));
        check("hyst a", 32'(ha), 32'(mdl[4][1:0]));
        check("hyst b", 32'(hb), 32'(mdl[5][1:0]));
        check("osc trim", 32'(ot), 32'(mdl[6][2:0]));
    endtask : check_fields

    // one apb transfer, compared against the model, then one idle cycle
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] ad, input logic [31:0] d,
                        input logic [3:0] s);
        int n;
        int k;
        logic ok;
        k = int'(ad[ADDR_W-1:2]) - int'(`FIRST_IDX);
        ok = ad[1:0] == 2'b00 && k >= 0 && k < 7;
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= w;
        i_paddr <= ad;
        i_pwdata <= d;
        i_pstrb <= w ? s : 4'h0;
        @(posedge i_ref_clk);
        i_penable <= 1'b1;
        n = 0;
        do begin
            @(posedge i_ref_clk);
            n++;
        end while (o_pready !== 1'b1);
        check("pready wait", n, 1);
        check("slave error", 32'(o_pslverr), 32'(!ok));
        if (!w) check("read data", o_prdata, ok ? 32'(mdl[k]) : 32'h0);
        if (w && ok && s[0]) mdl[k] = d[7:0];
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        @(posedge i_ref_clk);
        if (w) check_fields;
    endtask : xfer

    initial begin
        #100us;
        errors++;
        complete_run;
    end

    initial begin
        seed = 89;
        for (int k = 0; k < 7; k++) mdl[k] = rst_tab[k];
        repeat (5) @(posedge i_ref_clk);
        check_fields;
        i_rst_b <= 1'b1;
        for (int k = 0; k < 7; k++) xfer(1'b0, ADDR_W'(4 * (`FIRST_IDX + k)), 32'h0, 4'h0);
        $display("reset value test done");
        for (int k = 0; k < 7; k++) begin
            for (int p = 0; p < 4; p++) begin
                a = ADDR_W'(4 * (`FIRST_IDX + k));
                xfer(1'b1, a, p == 0 ? 32'hffff_ffff : p == 1 ? 32'h0 : $random(seed),
                     p == 2 ? 4'he : 4'hf);
                xfer(1'b0, a, 32'h0, 4'h0);
            end
        end
        $display("pattern and strobe test done");
        foreach (bad_tab[i]) begin
            xfer(1'b1, bad_tab[i], 32'hffff_ffff, 4'hf);
            xfer(1'b0, bad_tab[i], 32'h0, 4'h0);
        end
        $display("refused address test done");
        repeat (60) begin
            a = ADDR_W'($random(seed));
            if (a[7]) a = ADDR_W'(4 * (`FIRST_IDX + $unsigned($random(seed)) % 7));
            xfer(1'($random(seed)), a, $random(seed), 4'($random(seed)));
        end
        $display("random traffic test done");
        i_rst_b <= 1'b0;
        repeat (5) @(posedge i_ref_clk);
        for (int k = 0; k < 7; k++) mdl[k] = rst_tab[k];
        check_fields;
        i_rst_b <= 1'b1;
        for (int k = 0; k < 7; k++) xfer(1'b0, ADDR_W'(4 * (`FIRST_IDX + k)), 32'h0, 4'h0);
        $display("mid-run reset test done");
        complete_run;
    end
endmodule : dac_modulator_tweak_regs_tb
`default_nettype wire
